// ===== dv/line_source.sv
`timescale 1ns/1ps
module line_source (
  input  wire logic mclk,    // System clock.
  input  wire logic viol_in, // Violation output of the monitor.
  output logic      bit_en,  // One-cycle bit strobe.
  output logic      pos,     // Positive mark.
  output logic      neg      // Negative mark.
);
  // The line starts idle with no strobe.
  initial
  begin
    bit_en = 1'b0;
    pos    = 1'b0;
    neg    = 1'b0;
  end

  // One bit every two cycles. Between bits the rails carry the inverse
  // of the last value, so a monitor that ignores the strobe is caught.
  task automatic send_bit(input logic p, input logic n, output logic v);
    @(posedge mclk);
    bit_en <= 1'b1;
    pos    <= p;
    neg    <= n;
    @(posedge mclk);
    bit_en <= 1'b0;
    pos    <= ~p;
    neg    <= ~n;
    #1 v = viol_in;
  endtask : send_bit
endmodule : line_source

// ===== dv/test_rx_line_loss_violation_monitor.sv
`timescale 1ns/1ps
module test_rx_line_loss_violation_monitor;
  logic        mclk, rst, analog_below, awvalid, wvalid, bready;
  logic        arvalid, rready, bit_en, pos, neg, viol, alf, dlf, ale;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          mismatches, n_compared, n_ev;
  // Analog runs: the three masks, timer select, then plain.
  localparam logic [39:0] ACTL = {8'h01, 8'h09, 8'h21, 8'h41, 8'h81};

  rx_line_loss_violation_monitor #(.ANALOG_LOSS_FLAG_MIN_CYCLES(50), .UI_DIV(5))
    u_rx_line_loss_violation_monitor (
    .mclk(mclk), .rst(rst), .rx_bit_en(bit_en), .rx_pos(pos),
    .rx_neg(neg), .analog_below(analog_below),
    .neg_rail_violation_out(viol), .analog_loss_flag(alf),
    .digital_loss_flag(dlf), .analog_loss_event(ale),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  line_source u_line_source (.mclk(mclk), .viol_in(viol),
    .bit_en(bit_en), .pos(pos), .neg(neg));

  // Free-running 10 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Interrupt pulses are counted at the settled half of the cycle.
  always @(negedge mclk)
    if (ale === 1'b1)
      n_ev++;

  // A hung handshake must still end the run with a verdict.
  initial
  begin
    #4000000;
    mismatches++;
    print_verdict();
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] e);
    n_compared++;
    if (got !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, e);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic e);
    check_word({31'h0, got}, {31'h0, e});
  endtask : check_bit

  // AMI reference: a mark that repeats the last polarity is a violation.
  function automatic logic exp_viol(logic p, logic n, logic last);
    return (p | n) && (p == last);
  endfunction : exp_viol

  // Address and data offered together; ready is judged mid-cycle.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    @(negedge mclk);
    while (awready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    @(negedge mclk);
    while (bvalid !== 1'b1) @(negedge mclk);
    r = bresp;
    @(posedge mclk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    @(negedge mclk);
    while (arready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    arvalid <= 1'b0;
    @(negedge mclk);
    while (rvalid !== 1'b1) @(negedge mclk);
    d = rdata;
    r = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic send_pat(int ones, int zeros, int reps);
    logic v;
    repeat (reps)
    begin
      repeat (ones) u_line_source.send_bit(1'b1, 1'b0, v);
      repeat (zeros) u_line_source.send_bit(1'b0, 1'b0, v);
    end
  endtask : send_pat

  // The loss flag may trail the bit by a cycle, so let two edges pass.
  task automatic dl_check(input logic e);
    repeat (2) @(posedge mclk);
    #1 check_bit(dlf, e);
  endtask : dl_check

  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence: registers, violations, digital loss, analog loss.
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c, cp, cn, ce;
    logic        v, p, n, last;
    int          k, cnt;
    {rst, analog_below, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, wdata, wstrb} = {8'h0, 32'h0, 4'hf};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    void'($urandom(32'hb5e2));
    axi_rd(rx_loss_pkg::CTRL_OFFS, d, r);
    check_word(d, {24'h0, rx_loss_pkg::CTRL_RESET});
    axi_rd(4'h8, d, r);
    check_word({d[29:0], r}, {30'h0, rx_loss_pkg::RESP_SLVERR});
    axi_wr(4'hc, 32'h0, r);
    check_word(32'(r), 32'(rx_loss_pkg::RESP_SLVERR));
    // Dual rail: the output is the negative rail, no violations.
    axi_wr(rx_loss_pkg::CTRL_OFFS, 32'h0, r);
    for (k = 0; k < 3; k++)
    begin
      u_line_source.send_bit(k == 2, k != 2, v);
      check_bit(v, k != 2);
    end
    // Single rail, uncoded: random AMI stream against the reference.
    axi_wr(rx_loss_pkg::CTRL_OFFS, 32'h1, r);
    u_line_source.send_bit(1'b1, 1'b0, v);
    last = 1'b1;
    repeat (200)
    begin
      k = $urandom % 3;
      p = (k == 1);
      n = (k == 2);
      u_line_source.send_bit(p, n, v);
      check_bit(v, exp_viol(p, n, last));
      if (p | n)
        last = p;
    end
    // Coded E1: 000V is a substitution, a bare repeat is flagged.
    axi_wr(rx_loss_pkg::CTRL_OFFS, 32'h7, r);
    {cp, cn, ce} = {8'b0100_0100, 8'b1000_0011, 8'b0000_0001};
    for (k = 0; k < 8; k++)
    begin
      u_line_source.send_bit(cp[7-k], cn[7-k], v);
      if (k > 0)
        check_bit(v, ce[7-k]);
    end
    // DS1 loose: exact zero count, run reset by a one, run limit 99.
    axi_wr(rx_loss_pkg::CTRL_OFFS, 32'h1, r);
    send_pat(0, 99, 1);
    dl_check(1'b0);
    send_pat(1, 99, 1);
    dl_check(1'b0);
    send_pat(0, 1, 1);
    dl_check(1'b1);
    send_pat(5, 20, 12);
    dl_check(1'b0);
    // DS1 strict: a 20-zero run blocks clearing, 3-zero runs do not.
    axi_wr(rx_loss_pkg::CTRL_OFFS, 32'h11, r);
    send_pat(0, 100, 1);
    dl_check(1'b1);
    send_pat(5, 20, 12);
    dl_check(1'b1);
    send_pat(1, 3, 75);
    dl_check(1'b0);
    // E1 with strict select, which has no effect there.
    axi_wr(rx_loss_pkg::CTRL_OFFS, 32'h15, r);
    // A leading one clears the zeros left over from the strict DS1 run.
    send_pat(1, 254, 1);
    dl_check(1'b0);
    send_pat(0, 1, 1);
    dl_check(1'b1);
    send_pat(5, 20, 31);
    dl_check(1'b0);
    // Analog loss timing, latched status and masked events.
    for (k = 0; k < 5; k++)
    begin
      c = ACTL[8*k +: 8];
      axi_wr(rx_loss_pkg::CTRL_OFFS, {24'h0, c}, r);
      n_ev = 0;
      cnt = 0;
      @(posedge mclk);
      analog_below <= 1'b1;
      @(negedge mclk);
      while (alf !== 1'b1 && cnt < 2000)
      begin
        cnt++;
        @(negedge mclk);
      end
      check_bit(cnt >= (c[3] ? 45 : 49), 1'b1);
      check_bit(cnt <= (c[3] ? 1280 : 133), 1'b1);
      @(posedge mclk);
      analog_below <= 1'b0;
      repeat (8) @(posedge mclk);
      check_word(32'(n_ev), 32'(c[7:5] == 3'h0));
      axi_rd(rx_loss_pkg::STATUS_OFFS, d, r);
      check_bit(d[0], 1'b1);
      axi_rd(rx_loss_pkg::STATUS_OFFS, d, r);
      check_bit(d[0] | d[2], 1'b0);
    end
    print_verdict();
  end
endmodule : test_rx_line_loss_violation_monitor

// ===== rtl/rx_line_loss_violation_monitor.sv
`timescale 1ns/1ps
module rx_line_loss_violation_monitor #(
  parameter int ANALOG_LOSS_FLAG_MIN_CYCLES = rx_loss_pkg::ANALOG_LOSS_FLAG_MIN_CYC,
  parameter int UI_DIV          = 5
) (
  input  wire logic        mclk,                // System clock, 10 MHz.
  input  wire logic        rst,                 // Synchronous reset.
  input  wire logic        rx_bit_en,           // One recovered bit.
  input  wire logic        rx_pos,              // Positive pulse.
  input  wire logic        rx_neg,              // Negative pulse.
  input  wire logic        analog_below,        // Amplitude lost.
  output logic             neg_rail_violation_out, // Violation or rail.
  output logic             analog_loss_flag,    // Live analog loss.
  output logic             digital_loss_flag,   // Live digital loss.
  output logic             analog_loss_event,   // Unmasked rise pulse.
  input  wire logic        awvalid,             // AXI write address.
  output logic             awready,             // AXI write address.
  input  wire logic [3:0]  awaddr,              // AXI write address.
  input  wire logic        wvalid,              // AXI write data.
  output logic             wready,              // AXI write data.
  input  wire logic [31:0] wdata,               // AXI write data.
  input  wire logic [3:0]  wstrb,               // AXI byte strobes.
  output logic             bvalid,              // AXI write response.
  input  wire logic        bready,              // AXI write response.
  output logic [1:0]       bresp,               // AXI write response.
  input  wire logic        arvalid,             // AXI read address.
  output logic             arready,             // AXI read address.
  input  wire logic [3:0]  araddr,              // AXI read address.
  output logic             rvalid,              // AXI read data.
  input  wire logic        rready,              // AXI read data.
  output logic [31:0]      rdata,               // AXI read data.
  output logic [1:0]       rresp                // AXI read response.
);
  rx_loss_pkg::ctrl_t   ctrl_reg;
  rx_loss_pkg::status_t stat_reg;
  logic                 wr_go;
  logic                 rd_go;
  logic                 pulse;
  logic                 last_pol_reg;
  logic [6:0]           hist_reg;
  logic                 is_viol;
  logic                 viol_ok;
  logic [7:0]           zero_reg;
  logic [7:0]           win_reg;
  logic [7:0]           ones_reg;
  logic [7:0]           run_max_reg;
  logic [7:0]           win_len;
  logic [7:0]           run_lim;
  logic                 clr_ok;
  logic [15:0]          cyc_reg;
  logic [7:0]           ui_reg;
  logic [7:0]           div_reg;
  logic                 ui_tick;
  logic                 analog_loss_flag_set;
  logic                 analog_loss_flag_rd_clr;

  // Write and read are taken whole in one cycle; one of each may be open.
  assign wr_go   = awvalid && wvalid && !bvalid;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign rd_go   = arvalid && !rvalid;
  assign arready = rd_go;

  // Control register; only the low byte lane holds fields.
  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_reg <= rx_loss_pkg::CTRL_RESET;
    else if (wr_go && awaddr == rx_loss_pkg::CTRL_OFFS && wstrb[0])
      ctrl_reg <= wdata[7:0];
  end

  // Write response, error on any address but the control word.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp  <= rx_loss_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp  <= (awaddr == rx_loss_pkg::CTRL_OFFS) ?
                rx_loss_pkg::RESP_OKAY : rx_loss_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Read data; unmapped words read zero with an error response.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= rx_loss_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rresp  <= rx_loss_pkg::RESP_OKAY;
      if (araddr == rx_loss_pkg::CTRL_OFFS)
        rdata <= {24'h0, ctrl_reg};
      else if (araddr == rx_loss_pkg::STATUS_OFFS)
        rdata <= {28'h0, stat_reg};
      else
      begin
        rdata <= 32'h0;
        rresp <= rx_loss_pkg::RESP_SLVERR;
      end
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Line symbol decode: a mark repeating the last polarity is a violation.
  assign pulse   = rx_pos || rx_neg;
  assign is_viol = rx_bit_en && pulse &&
                   ((rx_pos && rx_neg) || (rx_neg == last_pol_reg));
  always_comb
  begin
    if (!ctrl_reg.code_en)
      viol_ok = 1'b0;
    else if (ctrl_reg.e1_mode)
      viol_ok = (hist_reg[2:0] == 3'b000) || (hist_reg[1:0] == 2'b00);
    else
      viol_ok = (hist_reg[2:0] == 3'b000) ||
                (hist_reg[5:0] == 6'b000110);
  end

  // Polarity memory and mark history; history bit 0 is the newest.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      last_pol_reg <= 1'b1;
      hist_reg     <= 7'h0;
    end
    else if (rx_bit_en)
    begin
      hist_reg <= {hist_reg[5:0], pulse};
      if (pulse)
        last_pol_reg <= rx_neg;
    end
  end

  // Dual rail passes the negative rail through untouched.
  always_ff @(posedge mclk)
  begin
    if (rst)
      neg_rail_violation_out <= 1'b0;
    else if (!ctrl_reg.single_rail)
      neg_rail_violation_out <= rx_neg;
    else
      neg_rail_violation_out <= is_viol && !viol_ok;
  end

  // Zero run counter saturates so a long silence cannot wrap.
  always_ff @(posedge mclk)
  begin
    if (rst)
      zero_reg <= 8'h0;
    else if (rx_bit_en && pulse)
      zero_reg <= 8'h0;
    else if (rx_bit_en && zero_reg != 8'hff)
      zero_reg <= zero_reg + 8'h1;
  end

  assign win_len = ctrl_reg.e1_mode ? rx_loss_pkg::E1_ZEROS
                                    : rx_loss_pkg::DS1_ZEROS;
  assign run_lim = ctrl_reg.digital_loss_standard_select ?
                   rx_loss_pkg::DS1_RUN_STRICT : rx_loss_pkg::DS1_RUN_LOOSE;
  assign clr_ok = ({ones_reg, 3'b000} >= {3'b000, win_len}) &&
                  (ctrl_reg.e1_mode || run_max_reg <= run_lim);

  // Density is judged over back-to-back windows, not a sliding one.
  always_ff @(posedge mclk)
  begin
    if (rst || (rx_bit_en && win_reg == win_len - 8'h1))
    begin
      win_reg     <= 8'h0;
      ones_reg    <= 8'h0;
      run_max_reg <= 8'h0;
    end
    else if (rx_bit_en)
    begin
      win_reg <= win_reg + 8'h1;
      if (pulse)
        ones_reg <= ones_reg + 8'h1;
      if (!pulse && zero_reg + 8'h1 > run_max_reg && zero_reg != 8'hff)
        run_max_reg <= zero_reg + 8'h1;
    end
  end

  // Digital loss: set on a zero run, cleared only at a good window end.
  always_ff @(posedge mclk)
  begin
    if (rst)
      digital_loss_flag <= 1'b0;
    else if (rx_bit_en && !pulse && zero_reg + 8'h1 >= win_len &&
             zero_reg != 8'hff)
      digital_loss_flag <= 1'b1;
    else if (rx_bit_en && win_reg == win_len - 8'h1 && clr_ok)
      digital_loss_flag <= 1'b0;
  end

  // Unit interval tick from the reference clock; the line clock is gone.
  assign ui_tick = (div_reg == 8'(UI_DIV - 1));
  always_ff @(posedge mclk)
  begin
    if (rst || ui_tick)
      div_reg <= 8'h0;
    else
      div_reg <= div_reg + 8'h1;
  end

  // Loss timers run while the amplitude is low and restart on return.
  always_ff @(posedge mclk)
  begin
    if (rst || !analog_below)
    begin
      cyc_reg <= 16'h0;
      ui_reg  <= 8'h0;
    end
    else
    begin
      if (cyc_reg != 16'hffff)
        cyc_reg <= cyc_reg + 16'h1;
      if (ui_tick && ui_reg != 8'hff)
        ui_reg <= ui_reg + 8'h1;
    end
  end

  assign analog_loss_flag_set = analog_below &&
                    (ctrl_reg.analog_loss_timer_select ?
                     (ui_reg >= rx_loss_pkg::ANALOG_LOSS_FLAG_MIN_UI) :
                     (cyc_reg >= 16'(ANALOG_LOSS_FLAG_MIN_CYCLES)));

  always_ff @(posedge mclk)
  begin
    if (rst)
      analog_loss_flag <= 1'b0;
    else
      analog_loss_flag <= analog_loss_flag_set;
  end

  // Sticky status; a new event in the reading cycle survives the clear.
  assign analog_loss_flag_rd_clr = rd_go && araddr == rx_loss_pkg::STATUS_OFFS;
  always_ff @(posedge mclk)
  begin
    if (rst)
      stat_reg <= '0;
    else
    begin
      stat_reg.analog_loss_flag_live <= analog_loss_flag;
      stat_reg.digital_loss_flag_live <= digital_loss_flag;
      stat_reg.analog_loss_flag_latched <= analog_loss_flag ||
                               (stat_reg.analog_loss_flag_latched && !analog_loss_flag_rd_clr);
      stat_reg.digital_loss_flag_latched <= digital_loss_flag ||
                               (stat_reg.digital_loss_flag_latched && !analog_loss_flag_rd_clr);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      analog_loss_event <= 1'b0;
    else
      analog_loss_event <= analog_loss_flag_set && !analog_loss_flag &&
                           !(ctrl_reg.alarm_mask || ctrl_reg.channel_mask ||
                             ctrl_reg.global_mask);
  end

  a_dual_passes: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_reg.single_rail |=> neg_rail_violation_out == $past(rx_neg))
    else $error("dual rail output not the negative rail");
  a_raw_viol: assert property (@(posedge mclk) disable iff (rst)
    ctrl_reg.single_rail && !ctrl_reg.code_en && is_viol
    |=> neg_rail_violation_out)
    else $error("uncoded violation not reported");
  a_coded_ok: assert property (@(posedge mclk) disable iff (rst)
    ctrl_reg.single_rail && !is_viol |=> !neg_rail_violation_out)
    else $error("violation reported without cause");
  a_ds1_set: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_reg.e1_mode && rx_bit_en && !pulse && zero_reg == 8'h63
    |=> digital_loss_flag)
    else $error("DS1 loss missed at 100 zeros");
  a_e1_set: assert property (@(posedge mclk) disable iff (rst)
    ctrl_reg.e1_mode && $rose(digital_loss_flag)
    |-> $past(zero_reg) == 8'hfe)
    else $error("E1 loss set at wrong count");
  a_run_clear: assert property (@(posedge mclk) disable iff (rst)
    rx_bit_en && pulse |=> zero_reg == 8'h0)
    else $error("zero run not cleared by a one");
  a_analog_loss_flag_early: assert property (@(posedge mclk) disable iff (rst)
    $rose(analog_loss_flag) && !ctrl_reg.analog_loss_timer_select
    |-> $past(cyc_reg) >= 16'(ANALOG_LOSS_FLAG_MIN_CYCLES))
    else $error("analog loss declared too early");
  a_analog_loss_flag_ui: assert property (@(posedge mclk) disable iff (rst)
    $rose(analog_loss_flag) && ctrl_reg.analog_loss_timer_select
    |-> $past(ui_reg) >= 8'h0a)
    else $error("analog loss declared under 10 UI");
  a_analog_loss_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
    stat_reg.analog_loss_flag_latched && !analog_loss_flag_rd_clr |=> stat_reg.analog_loss_flag_latched)
    else $error("latched analog loss dropped without read");
endmodule : rx_line_loss_violation_monitor

// ===== rtl/rx_loss_pkg.sv
package rx_loss_pkg;
  localparam logic [3:0] CTRL_OFFS   = 4'h0;
  localparam logic [3:0] STATUS_OFFS = 4'h4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_NS         = 100;
  localparam int ANALOG_LOSS_FLAG_MIN_US    = 1000;
  localparam int ANALOG_LOSS_FLAG_MAX_US    = 2600;
  localparam int ANALOG_LOSS_FLAG_MIN_CYC   = (ANALOG_LOSS_FLAG_MIN_US*1000 + CLK_NS - 1) / CLK_NS;
  localparam int ANALOG_LOSS_FLAG_MAX_CYC   = (ANALOG_LOSS_FLAG_MAX_US*1000) / CLK_NS;
  localparam logic [7:0] ANALOG_LOSS_FLAG_MIN_UI = 8'h0a;
  localparam logic [7:0] ANALOG_LOSS_FLAG_MAX_UI = 8'hff;
  localparam logic [7:0] DS1_ZEROS   = 8'h64;
  localparam logic [7:0] E1_ZEROS    = 8'hff;
  localparam logic [7:0] DS1_RUN_STRICT = 8'h0f;
  localparam logic [7:0] DS1_RUN_LOOSE  = 8'h63;
  localparam int DENSITY_SHIFT  = 3;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  // Control fields; bit 0 is the least significant member.
  typedef struct packed {
    logic global_mask;
    logic channel_mask;
    logic alarm_mask;
    logic digital_loss_standard_select;
    logic analog_loss_timer_select;
    logic e1_mode;
    logic code_en;
    logic single_rail;
  } ctrl_t;
  typedef struct packed {
    logic digital_loss_flag_live;
    logic analog_loss_flag_live;
    logic digital_loss_flag_latched;
    logic analog_loss_flag_latched;
  } status_t;
endpackage : rx_loss_pkg
